/* hdl/atc_cmp_if.sv */
// Carrier between the controller and its result comparator.
`timescale 1ns/10ps
interface atc_cmp_if;
  logic [15:0] result;
  logic [15:0] thr1;
  logic [15:0] thr2;
  logic        sgn;
  logic        en;
  logic        gt;
  logic        range;
  logic        pass;
  modport ctl (output result, thr1, thr2, sgn, en, gt, range, input pass);
  modport cmp (input result, thr1, thr2, sgn, en, gt, range, output pass);
endinterface

/* hdl/atc_compare.sv */
// Threshold and range comparator for conversion results.
`timescale 1ns/10ps
module atc_compare (
  atc_cmp_if.cmp cif
);

  logic lo1;
  logic hi2;
  logic ordered;

  // Pass decides whether a finished result is kept.
  always_comb begin
    lo1     = atc_pkg::atc_lt(cif.result, cif.thr1, cif.sgn);
    hi2     = atc_pkg::atc_lt(cif.thr2, cif.result, cif.sgn);
    ordered = !atc_pkg::atc_lt(cif.thr2, cif.thr1, cif.sgn);
    if (!cif.en) begin
      cif.pass = 1'b1;
    end else if (!cif.range) begin
      cif.pass = cif.gt ? !lo1 : lo1;
    end else if (!cif.gt) begin
      cif.pass = ordered ? (lo1 | hi2) : (lo1 & hi2);
    end else begin
      cif.pass = ordered ? (!lo1 & !hi2) : (!lo1 | !hi2);
    end
  end

endmodule

/* hdl/atc_ctrl.sv */
// Converter trigger, compare and status control with APB registers.
//
// Functional notes
// - Control bits 31 to 8 are read-only and read as zero.
// - Active flag sets when a conversion starts, clears on finish or abort.
// - Active flag stays set through a whole averaging sequence.
// - Trigger select bit: 0 software trigger, 1 hardware trigger.
// - Software mode starts a conversion on a channel control write.
// - Hardware mode starts on trigger input after a select pulse armed it.
// - Compare enable bit turns the result compare on or off.
// - Compare greater bit picks less-than/exclusive or greater-equal/inclusive.
// - Greater and range bits are ignored while compare is disabled.
// - Range off compares to value one only; on uses both values.
// - Range mode tests inside or outside, chosen by the greater bit.
// - DMA enable raises the DMA request whenever a complete flag sets.
// - Reference code 00 default pair, 01 alternate pair, others reserved.
// - Compare values follow the result format and signedness of the mode.
// - Calibration fails and flags if hardware trigger is selected meanwhile.
//
// Implementation choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/10ps
module atc_ctrl (
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        ce,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        hw_trigger_input,
  input  wire logic        hw_trigger_select_pulse,
  input  wire logic        analog_done,
  input  wire logic [15:0] analog_data,
  output logic             conv_start,
  output logic      [4:0]  conv_channel,
  output logic             conv_diff,
  output logic             ref_alt_select,
  output logic             dma_req,
  output logic             irq
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    atc_pkg::atc_state_type state;
    logic [4:0]             chan;
    logic                   diff;
    logic                   cplt;
    logic                   trig_sel;
    logic                   cmp_en;
    logic                   cmp_gt;
    logic                   cmp_range;
    logic                   dma_en;
    logic [1:0]             ref_pair;
    logic [15:0]            thr1;
    logic [15:0]            thr2;
    logic [15:0]            result;
    logic                   avg_en;
    logic                   cal_fail;
    logic                   hw_armed;
    logic                   trig_q;
    logic                   sel_q;
    logic [1:0]             avg_cnt;
    logic [17:0]            acc;
    logic [5:0]             cal_cnt;
    logic [2:0]             ists;
    logic [2:0]             imsk;
    logic [31:0]            prdata;
    logic                   pready;
    logic                   pslverr;
    logic                   conv_start;
    logic                   dma_req;
    logic                   irq;
    logic                   ref_alt;
  } atc_ctrl_state_type;

  atc_ctrl_state_type r;
  atc_ctrl_state_type n;

  logic        wr;
  logic        rd;
  logic        chan_wr;
  logic        cal_go;
  logic        sw_start;
  logic        hw_fire;
  logic        last_done;
  logic        trig_s;
  logic        sel_s;
  logic        hit;
  logic [31:0] rdata;
  logic [17:0] acc_sum;
  logic [15:0] final_val;
  logic [2:0]  ev;
  logic [2:0]  w1c;

  atc_cmp_if cif ();

  // ---------------------------------------------------------------
  // Submodules
  // ---------------------------------------------------------------
  atc_sync u_sync_trig (
    .clk     (clk),
    .reset_n (reset_n),
    .ce      (ce),
    .din     (hw_trigger_input),
    .dout    (trig_s)
  );

  atc_sync u_sync_sel (
    .clk     (clk),
    .reset_n (reset_n),
    .ce      (ce),
    .din     (hw_trigger_select_pulse),
    .dout    (sel_s)
  );

  atc_compare u_cmp (
    .cif (cif)
  );

  // Comparator inputs: the result about to be stored and the live settings.
  assign cif.result = final_val;
  assign cif.thr1   = r.thr1;
  assign cif.thr2   = r.thr2;
  assign cif.sgn    = r.diff;
  assign cif.en     = r.cmp_en;
  assign cif.gt     = r.cmp_gt;
  assign cif.range  = r.cmp_range;

  // ---------------------------------------------------------------
  // Decode of bus transfers and start conditions
  // ---------------------------------------------------------------
  // A transfer completes on the access edge where ready is high.
  assign wr       = psel & penable & r.pready & pwrite;
  assign rd       = psel & penable & r.pready & ~pwrite;
  assign chan_wr  = wr & (paddr == atc_pkg::OFS_CHAN);
  assign cal_go   = wr & (paddr == atc_pkg::OFS_CAL) & pwdata[atc_pkg::CAL_RUN_BIT]
                    & (r.state != atc_pkg::ST_CAL);
  assign sw_start = chan_wr & ~r.trig_sel & (r.state != atc_pkg::ST_CAL);
  assign hw_fire  = trig_s & ~r.trig_q & r.trig_sel & r.hw_armed
                    & (r.state == atc_pkg::ST_IDLE) & ~cal_go;

  // Running sum with sign extension in differential mode.
  assign acc_sum   = r.acc + {{2{analog_data[15] & r.diff}}, analog_data};
  assign final_val = r.avg_en ? 16'(acc_sum >> atc_pkg::AVG_SHIFT) : analog_data;
  assign last_done = (r.state == atc_pkg::ST_CONV) & analog_done & ~chan_wr & ~cal_go
                     & (~r.avg_en | (r.avg_cnt == atc_pkg::AVG_LAST));

  // ---------------------------------------------------------------
  // Read multiplexer
  // ---------------------------------------------------------------
  // Unlisted bits stay zero, including the upper control bits.
  always_comb begin
    rdata = atc_pkg::WORD_ZERO;
    hit   = 1'b1;
    case (paddr)
      atc_pkg::OFS_CHAN: begin
        rdata[atc_pkg::CHAN_CPLT_BIT]     = r.cplt;
        rdata[atc_pkg::CHAN_DIFF_BIT]     = r.diff;
        rdata[atc_pkg::CHAN_SEL_MSB:0]    = r.chan;
      end
      atc_pkg::OFS_RESULT: rdata[15:0] = r.result;
      atc_pkg::OFS_THR1:   rdata[15:0] = r.thr1;
      atc_pkg::OFS_THR2:   rdata[15:0] = r.thr2;
      atc_pkg::OFS_CTRL: begin
        rdata[atc_pkg::CTRL_ACT_BIT]      = (r.state == atc_pkg::ST_CONV);
        rdata[atc_pkg::CTRL_TRIG_BIT]     = r.trig_sel;
        rdata[atc_pkg::CTRL_CMPEN_BIT]    = r.cmp_en;
        rdata[atc_pkg::CTRL_CMPGT_BIT]    = r.cmp_gt;
        rdata[atc_pkg::CTRL_RANGE_BIT]    = r.cmp_range;
        rdata[atc_pkg::CTRL_DMA_BIT]      = r.dma_en;
        rdata[atc_pkg::CTRL_REF_MSB:0]    = r.ref_pair;
      end
      atc_pkg::OFS_CAL: begin
        rdata[atc_pkg::CAL_RUN_BIT]       = (r.state == atc_pkg::ST_CAL);
        rdata[atc_pkg::CAL_FAIL_BIT]      = r.cal_fail;
        rdata[atc_pkg::CAL_AVG_BIT]       = r.avg_en;
      end
      atc_pkg::OFS_ISTS:   rdata[2:0] = r.ists;
      atc_pkg::OFS_IMSK:   rdata[2:0] = r.imsk;
      default:             hit = 1'b0;
    endcase
  end

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    n            = r;
    ev           = atc_pkg::INT_RESET;
    w1c          = atc_pkg::INT_RESET;
    n.conv_start = 1'b0;
    n.trig_q     = trig_s;
    n.sel_q      = sel_s;

    // Bus slave: data and ready are registered in the setup cycle.
    n.pready  = psel & ~penable;
    n.pslverr = 1'b0;
    if (psel & ~penable) begin
      n.prdata  = pwrite ? atc_pkg::WORD_ZERO : rdata;
      n.pslverr = ~hit;
    end

    // Reading the result consumes the complete flag.
    if (rd & (paddr == atc_pkg::OFS_RESULT)) begin
      n.cplt = 1'b0;
    end

    // Register writes.
    if (wr) begin
      case (paddr)
        atc_pkg::OFS_CHAN: begin
          n.chan = pwdata[atc_pkg::CHAN_SEL_MSB:0];
          n.diff = pwdata[atc_pkg::CHAN_DIFF_BIT];
          n.cplt = 1'b0;
          if (r.state == atc_pkg::ST_CONV) begin
            n.state = atc_pkg::ST_IDLE;
          end
        end
        atc_pkg::OFS_THR1: n.thr1 = pwdata[15:0];
        atc_pkg::OFS_THR2: n.thr2 = pwdata[15:0];
        atc_pkg::OFS_CTRL: begin
          n.trig_sel  = pwdata[atc_pkg::CTRL_TRIG_BIT];
          n.cmp_en    = pwdata[atc_pkg::CTRL_CMPEN_BIT];
          n.cmp_gt    = pwdata[atc_pkg::CTRL_CMPGT_BIT];
          n.cmp_range = pwdata[atc_pkg::CTRL_RANGE_BIT];
          n.dma_en    = pwdata[atc_pkg::CTRL_DMA_BIT];
          n.ref_pair  = pwdata[atc_pkg::CTRL_REF_MSB:0];
        end
        atc_pkg::OFS_CAL: begin
          n.avg_en = pwdata[atc_pkg::CAL_AVG_BIT];
          if (pwdata[atc_pkg::CAL_FAIL_BIT]) begin
            n.cal_fail = 1'b0;
          end
          if (cal_go) begin
            n.state   = atc_pkg::ST_CAL;
            n.cal_cnt = '0;
          end
        end
        atc_pkg::OFS_ISTS: w1c    = pwdata[2:0];
        atc_pkg::OFS_IMSK: n.imsk = pwdata[2:0];
        default: ;
      endcase
    end

    // A select pulse arms the hardware trigger.
    if (sel_s & ~r.sel_q) begin
      n.hw_armed = 1'b1;
    end

    // Conversion and calibration sequencing.
    unique case (r.state)
      atc_pkg::ST_IDLE: ;
      atc_pkg::ST_CONV: begin
        if (analog_done & ~chan_wr & ~cal_go) begin
          if (!last_done) begin
            n.avg_cnt    = r.avg_cnt + 2'h1;
            n.acc        = acc_sum;
            n.conv_start = 1'b1;
          end else begin
            n.state = atc_pkg::ST_IDLE;
            if (cif.pass) begin
              n.result       = final_val;
              n.cplt         = 1'b1;
              ev[atc_pkg::INT_CPLT] = 1'b1;
            end
          end
        end
      end
      atc_pkg::ST_CAL: begin
        if (r.trig_sel | wr) begin
          n.state    = atc_pkg::ST_IDLE;
          n.cal_fail = 1'b1;
          ev[atc_pkg::INT_CALFAIL] = 1'b1;
        end else if (r.cal_cnt == atc_pkg::CAL_CNT_LAST) begin
          n.state = atc_pkg::ST_IDLE;
          ev[atc_pkg::INT_CALDONE] = 1'b1;
        end else begin
          n.cal_cnt = r.cal_cnt + 6'h01;
        end
      end
    endcase

    // A new start overrides whatever conversion was under way.
    if (sw_start | hw_fire) begin
      n.state      = atc_pkg::ST_CONV;
      n.avg_cnt    = '0;
      n.acc        = '0;
      n.conv_start = 1'b1;
      // A select pulse in the firing cycle arms again, so the set wins.
      if (hw_fire) begin
        n.hw_armed = sel_s & ~r.sel_q;
      end
    end

    // Sticky status: a new event beats a clear in the same cycle.
    n.ists    = (r.ists & ~w1c) | ev;
    n.irq     = |(n.ists & n.imsk);
    n.dma_req = n.cplt & n.dma_en;
    n.ref_alt = (n.ref_pair == atc_pkg::REF_ALT);
  end

  // State register, frozen while the clock enable is low.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      r       <= '0;
      r.state <= atc_pkg::ST_IDLE;
    end else if (ce) begin
      r <= n;
    end
  end

  assign prdata         = r.prdata;
  assign pready         = r.pready;
  assign pslverr        = r.pslverr;
  assign conv_start     = r.conv_start;
  assign conv_channel   = r.chan;
  assign conv_diff      = r.diff;
  assign ref_alt_select = r.ref_alt;
  assign dma_req        = r.dma_req;
  assign irq            = r.irq;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n || !ce);

  property p_rsvd_zero;
    psel && !penable && !pwrite && paddr == atc_pkg::OFS_CTRL |=> prdata[31:8] == 24'h00_0000;
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved control bits not zero");

  property p_start_active;
    r.conv_start |-> r.state == atc_pkg::ST_CONV;
  endproperty
  a_start_active: assert property (p_start_active) else $error("start without active flag");

  property p_avg_hold;
    r.state == atc_pkg::ST_CONV && r.avg_en && analog_done && !chan_wr && !cal_go
      && r.avg_cnt != atc_pkg::AVG_LAST |=> r.state == atc_pkg::ST_CONV && r.conv_start;
  endproperty
  a_avg_hold: assert property (p_avg_hold) else $error("active dropped during averaging");

  property p_hw_blocks_sw;
    chan_wr && r.trig_sel && !hw_fire |=> !r.conv_start;
  endproperty
  a_hw_blocks_sw: assert property (p_hw_blocks_sw) else $error("software start in hw mode");

  property p_sw_start;
    chan_wr && !r.trig_sel && r.state != atc_pkg::ST_CAL |=> r.conv_start ##1 !r.conv_start;
  endproperty
  a_sw_start: assert property (p_sw_start) else $error("software start missing");

  property p_hw_start;
    hw_fire && !(sel_s && !r.sel_q) |=> r.conv_start && !r.hw_armed;
  endproperty
  a_hw_start: assert property (p_hw_start) else $error("hardware start missing");

  property p_dma;
    $rose(r.cplt) && r.dma_en |-> r.dma_req;
  endproperty
  a_dma: assert property (p_dma) else $error("DMA request missing");

  property p_cmp_off;
    last_done && !r.cmp_en |=> r.cplt && r.result == $past(final_val);
  endproperty
  a_cmp_off: assert property (p_cmp_off) else $error("result dropped with compare off");

  property p_cmp_drop;
    last_done && !cif.pass |=> r.result == $past(r.result) && r.state == atc_pkg::ST_IDLE;
  endproperty
  a_cmp_drop: assert property (p_cmp_drop) else $error("failing result stored");

  property p_cal_fail;
    r.state == atc_pkg::ST_CAL && r.trig_sel |=> r.cal_fail ##1 r.ists[atc_pkg::INT_CALFAIL];
  endproperty
  a_cal_fail: assert property (p_cal_fail) else $error("calibration did not fail");

  property p_ref;
    wr && paddr == atc_pkg::OFS_CTRL && pwdata[1:0] == atc_pkg::REF_ALT |=> ref_alt_select;
  endproperty
  a_ref: assert property (p_ref) else $error("alternate reference not selected");

  c_sw_conv: cover property (sw_start ##[1:50] r.cplt);
  c_avg_conv: cover property (r.avg_en && r.conv_start ##[1:200] $rose(r.cplt));
  c_hw_conv: cover property (hw_fire ##[1:50] r.cplt);
  c_cal_fail: cover property ($rose(r.cal_fail));

endmodule

/* hdl/atc_pkg.sv */
// Shared constants, types and helpers of the trigger and compare control.
package atc_pkg;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned CAL_TIME_NS   = 3_200;
  // A least time, so the cycle count rounds up.
  localparam int unsigned CAL_CYCLES    = (CAL_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [5:0]  CAL_CNT_LAST  = 6'(CAL_CYCLES - 1);
  localparam logic [1:0]  AVG_LAST      = 2'h3;
  localparam int unsigned AVG_SHIFT     = 2;

  // ---------------------------------------------------------------
  // Register byte offsets
  // ---------------------------------------------------------------
  localparam logic [11:0] OFS_CHAN   = 12'h000;
  localparam logic [11:0] OFS_RESULT = 12'h010;
  localparam logic [11:0] OFS_THR1   = 12'h018;
  localparam logic [11:0] OFS_THR2   = 12'h01C;
  localparam logic [11:0] OFS_CTRL   = 12'h020;
  localparam logic [11:0] OFS_CAL    = 12'h024;
  localparam logic [11:0] OFS_ISTS   = 12'h028;
  localparam logic [11:0] OFS_IMSK   = 12'h02C;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int unsigned CHAN_CPLT_BIT  = 7;
  localparam int unsigned CHAN_DIFF_BIT  = 5;
  localparam int unsigned CHAN_SEL_MSB   = 4;
  localparam int unsigned CTRL_ACT_BIT   = 7;
  localparam int unsigned CTRL_TRIG_BIT  = 6;
  localparam int unsigned CTRL_CMPEN_BIT = 5;
  localparam int unsigned CTRL_CMPGT_BIT = 4;
  localparam int unsigned CTRL_RANGE_BIT = 3;
  localparam int unsigned CTRL_DMA_BIT   = 2;
  localparam int unsigned CTRL_REF_MSB   = 1;
  localparam int unsigned CAL_RUN_BIT    = 7;
  localparam int unsigned CAL_FAIL_BIT   = 6;
  localparam int unsigned CAL_AVG_BIT    = 2;
  localparam int unsigned INT_CPLT       = 0;
  localparam int unsigned INT_CALDONE    = 1;
  localparam int unsigned INT_CALFAIL    = 2;

  // ---------------------------------------------------------------
  // Codes and reset values
  // ---------------------------------------------------------------
  localparam logic [1:0]  REF_DEFAULT  = 2'h0;
  localparam logic [1:0]  REF_ALT      = 2'h1;
  localparam logic [15:0] VALUE_RESET  = 16'h0000;
  localparam logic [31:0] WORD_ZERO    = 32'h0000_0000;
  localparam logic [2:0]  INT_RESET    = 3'h0;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_CONV = 3'b010,
    ST_CAL  = 3'b100
  } atc_state_type;

  // Less-than in the number format of the active conversion mode.
  function automatic logic atc_lt(input logic [15:0] a, input logic [15:0] b,
                                  input logic sgn);
    return sgn ? ($signed(a) < $signed(b)) : (a < b);
  endfunction

endpackage

/* hdl/atc_sync.sv */
// Three-stage input synchroniser with agreement filter.
`timescale 1ns/10ps
module atc_sync (
  input  wire logic clk,
  input  wire logic reset_n,
  input  wire logic ce,
  input  wire logic din,
  output logic      dout
);

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic q;
  } atc_sync_state_type;

  atc_sync_state_type r;
  atc_sync_state_type n;

  // The first stage feeds only the second; the output moves once stages agree.
  always_comb begin
    n    = r;
    n.s1 = din;
    n.s2 = r.s1;
    n.s3 = r.s2;
    if (r.s2 == r.s3) begin
      n.q = r.s3;
    end
  end

  // State register, frozen while the clock enable is low.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      r <= '0;
    end else if (ce) begin
      r <= n;
    end
  end

  assign dout = r.q;

endmodule

/* sim/adc_trigger_compare_control_bench.sv */
// Self-checking bench for the converter trigger and compare control.
`timescale 1ns/10ps
module adc_trigger_compare_control_bench;
  localparam logic [11:0] A_CH = atc_pkg::OFS_CHAN;
  localparam logic [11:0] A_CT = atc_pkg::OFS_CTRL;
  localparam logic [11:0] A_IS = atc_pkg::OFS_ISTS;
  localparam logic [11:0] A_IM = atc_pkg::OFS_IMSK;
  // Each row: control, channel, first compare value, sample, stored.
  localparam logic [48:0] TC [11] = '{
    {8'h1C, 8'h00, 16'h0064, 16'h0032, 1'b1}, {8'h24, 8'h00, 16'h0064, 16'h0063, 1'b1},
    {8'h24, 8'h00, 16'h0064, 16'h0064, 1'b0}, {8'h34, 8'h00, 16'h0064, 16'h0064, 1'b1},
    {8'h34, 8'h00, 16'h0064, 16'h0063, 1'b0}, {8'h34, 8'h00, 16'h0064, 16'h00C9, 1'b1},
    {8'h2C, 8'h00, 16'h0064, 16'h0064, 1'b0}, {8'h2C, 8'h00, 16'h0064, 16'h00C9, 1'b1},
    {8'h3C, 8'h00, 16'h0064, 16'h00C8, 1'b1}, {8'h3C, 8'h00, 16'h0064, 16'h00C9, 1'b0},
    {8'h24, 8'h20, 16'hFFF0, 16'h0010, 1'b0}};
  logic        clk, reset_n, psel, penable, pwrite, pready, pslverr, hw_trig, hw_sel;
  logic        done, conv_start, diff, ref_alt, dma_req, irq, err, ce;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [15:0] data, sample;
  logic [4:0]  chan;
  logic [48:0] r;
  int          mismatches, n_compared, cycles, starts, s0;

  atc_ctrl DUT (.clk(clk), .reset_n(reset_n), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .hw_trigger_input(hw_trig), .hw_trigger_select_pulse(hw_sel),
    .analog_done(done), .analog_data(data), .conv_start(conv_start), .conv_channel(chan),
    .conv_diff(diff), .ref_alt_select(ref_alt), .dma_req(dma_req), .irq(irq));
  atc_analog_model PM (.clk(clk), .reset_n(reset_n), .conv_start(conv_start),
    .sample(sample), .analog_done(done), .analog_data(data));

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t ns: saw %h, expected %h", $time, got, exp);
    end
  endtask

  // One APB transfer; the request is held until pready is sampled high.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    check(32'(n), 32'h0000_0001);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    check(q, exp);
  endtask

  // Polls the active flag until the conversion is over, then lets outputs settle.
  task automatic wait_idle();
    int n;
    n = 0;
    do begin
      apb(1'b0, A_CT, 32'h0000_0000);
      n++;
    end while (q[7] !== 1'b0 && n < 40);
    check({31'h0, q[7]}, 32'h0);
    repeat (2) @(posedge clk);
  endtask

  task automatic end_sim();
    $display("Comparisons %0d, mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Clock, start counter and timeout
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles++;
    if (conv_start === 1'b1) begin
      starts++;
    end
    if (cycles == 20000) begin
      mismatches++;
      end_sim();
    end
  end

  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial begin
    {reset_n, psel, penable, pwrite, hw_trig, hw_sel, ce} = 7'h01;
    {paddr, pwdata, sample} = '0;
    {mismatches, n_compared, cycles, starts} = '0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    rd(A_CT, 32'h0000_0000);
    wr(A_CT, 32'hFFFF_FFBF);
    rd(A_CT, 32'h0000_003F);
    for (int c = 0; c < 4; c++) begin
      wr(A_CT, 32'(c));
      repeat (2) @(posedge clk);
      check({31'h0, ref_alt}, {31'h0, c == 1});
      rd(A_CT, 32'(c));
    end
    apb(1'b0, 12'h0FC, 32'h0000_0000);
    check({31'h0, err}, 32'h1);
    $display("Test registers finished.");
    wr(A_IM, 32'h0000_0001);
    wr(A_CT, 32'h0000_0004);
    sample <= 16'h0123;
    wr(A_CH, 32'h0000_0003);
    rd(A_CT, 32'h0000_0084);
    wait_idle();
    check({31'h0, dma_req}, 32'h1);
    check({31'h0, irq}, 32'h1);
    check({27'h0, chan}, 32'h0000_0003);
    rd(A_CH, 32'h0000_0083);
    rd(atc_pkg::OFS_RESULT, 32'h0000_0123);
    repeat (2) @(posedge clk);
    check({31'h0, dma_req}, 32'h0);
    rd(A_IS, 32'h0000_0001);
    wr(A_IS, 32'h0000_0001);
    wr(A_IM, 32'h0000_0000);
    wr(A_CT, 32'h0000_0000);
    wr(A_CH, 32'h0000_0003);
    wait_idle();
    check({30'h0, dma_req, irq}, 32'h0);
    rd(A_IS, 32'h0000_0001);
    // A frozen block holds its start request, so the analog model keeps restarting and the conversion is still active.
    wr(A_CH, 32'h0000_0003);
    ce <= 1'b0;
    repeat (20) @(posedge clk);
    ce <= 1'b1;
    rd(A_CT, 32'h0000_0080);
    wait_idle();
    $display("Test software conversion finished.");
    wr(atc_pkg::OFS_CAL, 32'h0000_0004);
    sample <= 16'h0200;
    wr(A_CH, 32'h0000_0001);
    repeat (12) @(posedge clk);
    rd(A_CT, 32'h0000_0080);
    wait_idle();
    rd(atc_pkg::OFS_RESULT, 32'h0000_0200);
    wr(atc_pkg::OFS_CAL, 32'h0000_0000);
    $display("Test averaging finished.");
    wr(atc_pkg::OFS_THR2, 32'h0000_00C8);
    foreach (TC[i]) begin
      r = TC[i];
      wr(atc_pkg::OFS_THR1, {16'h0000, r[32:17]});
      wr(A_CT, {24'h0, r[48:41]});
      sample <= r[16:1];
      wr(A_CH, {24'h0, r[40:33]});
      wait_idle();
      rd(A_CH, {24'h0, r[0], r[39:33]});
      check({31'h0, dma_req}, {31'h0, r[0]});
      check({26'h0, diff, chan}, {26'h0, r[38:33]});
    end
    $display("Test compare finished.");
    wr(A_CT, 32'h0000_0040);
    s0 = starts;
    hw_trig <= 1'b1;
    repeat (10) @(posedge clk);
    hw_trig <= 1'b0;
    repeat (6) @(posedge clk);
    check(32'(starts), 32'(s0));
    hw_sel <= 1'b1;
    repeat (4) @(posedge clk);
    hw_sel <= 1'b0;
    repeat (6) @(posedge clk);
    hw_trig <= 1'b1;
    repeat (10) @(posedge clk);
    hw_trig <= 1'b0;
    check(32'(starts), 32'(s0 + 1));
    wait_idle();
    wr(A_CH, 32'h0000_0002);
    repeat (10) @(posedge clk);
    check(32'(starts), 32'(s0 + 1));
    $display("Test hardware trigger finished.");
    wr(atc_pkg::OFS_CAL, 32'h0000_0080);
    repeat (40) @(posedge clk);
    rd(atc_pkg::OFS_CAL, 32'h0000_0040);
    // With software trigger and no writes the calibration runs to its end.
    wr(A_CT, 32'h0000_0000);
    wr(atc_pkg::OFS_CAL, 32'h0000_00C0);
    repeat (40) @(posedge clk);
    rd(atc_pkg::OFS_CAL, 32'h0000_0000);
    rd(A_IS, 32'h0000_0007);
    $display("Test calibration finished.");
    end_sim();
  end
endmodule

/* sim/atc_analog_model.sv */
// Behavioural analog core that answers a start request after a delay; each new request restarts the delay.
`timescale 1ns/10ps
module atc_analog_model #(
  parameter int DLY = 6
) (
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        conv_start,
  input  wire logic [15:0] sample,
  output logic             analog_done,
  output logic      [15:0] analog_data
);
  int          cnt;
  logic [15:0] last_r;

  // ----------------------------------------
  // Conversion timing
  // ----------------------------------------
  // Outside the done cycle the data lines show the inverse of the last
  // sample, so stale data can never pass for a fresh one.
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt <= 0;
      analog_done <= 1'b0;
      last_r <= 16'h0000;
      analog_data <= 16'hFFFF;
    end else begin
      analog_done <= 1'b0;
      analog_data <= ~last_r;
      if (conv_start) begin
        cnt <= DLY;
      end else if (cnt == 1) begin
        cnt <= 0;
        analog_done <= 1'b1;
        analog_data <= sample;
        last_r <= sample;
      end else if (cnt > 1) begin
        cnt <= cnt - 1;
      end
    end
  end
endmodule
